// >>> design/pressure_threshold_interrupt_ref.sv
`timescale 1ns/1ps

module pressure_threshold_interrupt_ref (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire pth_pkg::reg_req_type req,
  output logic [7:0]                rdata,
  input  wire logic                 sample_valid,
  input  wire logic [23:0]          sample_raw,
  output logic [23:0]               pressure_out,
  output logic                      int_req
);
  import pth_pkg::*;

  // ==========================================
  // state
  cfg_type     cfg_q,   cfg_d;
  logic [7:0]  pressure_threshold_low_byte_q, pressure_threshold_low_byte_d;
  logic [7:0]  ths_h_q, ths_h_d;
  logic [15:0] def_q,   def_d;
  logic [23:0] ref_q,   ref_d;
  logic [23:0] hid_q,   hid_d;
  logic        arp_q,   arp_d;
  logic        az_q,    az_d;
  logic [23:0] pout_q,  pout_d;
  logic [2:0]  src_q,   src_d;
  logic        int_q,   int_d;
  logic [7:0]  rd_q,    rd_d;

  logic        cfg_wr;
  logic        src_rd;
  logic [15:0] ths_full;
  logic signed [24:0] thr;
  logic signed [24:0] diff;
  logic        hi_cmp;
  logic        lo_cmp;

  function automatic logic wr_at(input reg_req_type r, input logic [7:0] a);
    wr_at = r.wr && (r.addr == a);
  endfunction : wr_at

  assign cfg_wr = wr_at(req, ADDR_CFG);
  assign src_rd = req.rd && (req.addr == ADDR_SRC);

  // ==========================================
  // configuration and reference registers
  always_comb begin
    cfg_d   = cfg_q;
    pressure_threshold_low_byte_d = pressure_threshold_low_byte_q;
    ths_h_d = ths_h_q;
    def_d   = def_q;
    ref_d   = ref_q;
    hid_d   = hid_q;
    arp_d   = arp_q;
    az_d    = az_q;
    if (cfg_wr) begin
      cfg_d.autozero                    = req.wdata[BIT_AUTOZERO];
      cfg_d.differential_compute_enable = req.wdata[BIT_DIFF];
      cfg_d.latch_interrupt_request     = req.wdata[BIT_LATCH];
      cfg_d.low_event_enable            = req.wdata[BIT_LOW];
      cfg_d.high_event_enable           = req.wdata[BIT_HIGH];
    end
    if (wr_at(req, ADDR_THS_L)) begin
      pressure_threshold_low_byte_d = req.wdata;
    end
    if (wr_at(req, ADDR_THS_H)) begin
      ths_h_d = req.wdata;
    end
    if (wr_at(req, ADDR_DEF_L)) begin
      def_d[7:0] = req.wdata;
    end
    if (wr_at(req, ADDR_DEF_H)) begin
      def_d[15:8] = req.wdata;
    end
    if (wr_at(req, ADDR_REF_XL)) begin
      ref_d[7:0] = req.wdata;
    end
    if (wr_at(req, ADDR_REF_L)) begin
      ref_d[15:8] = req.wdata;
    end
    if (wr_at(req, ADDR_REF_H)) begin
      ref_d[23:16] = req.wdata;
    end
    if (cfg_wr && req.wdata[BIT_AUTO_REF]) begin
      hid_d = pout_q;
      arp_d = 1'b1;
    end
    if (cfg_wr && req.wdata[BIT_AUTO_REF_RST]) begin
      arp_d = 1'b0;
    end
    if (cfg_wr && req.wdata[BIT_AUTOZERO]) begin
      ref_d = pout_q;
      az_d  = 1'b1;
    end
    if (cfg_wr && req.wdata[BIT_AZ_RST]) begin
      ref_d = {def_q, 8'h00};
      az_d  = 1'b0;
      cfg_d.autozero = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q   <= '0;
      pressure_threshold_low_byte_q <= RST_BYTE;
      ths_h_q <= RST_BYTE;
      def_q   <= RST_REF_DEF;
      ref_q   <= '0;
      hid_q   <= '0;
      arp_q   <= 1'b0;
      az_q    <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      pressure_threshold_low_byte_q <= pressure_threshold_low_byte_d;
      ths_h_q <= ths_h_d;
      def_q   <= def_d;
      ref_q   <= ref_d;
      hid_q   <= hid_d;
      arp_q   <= arp_d;
      az_q    <= az_d;
    end
  end

  // ==========================================
  // pressure output path
  always_comb begin
    pout_d = pout_q;
    if (sample_valid) begin
      if (az_q) begin
        pout_d = sample_raw - ref_q;
      end else begin
        pout_d = sample_raw;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pout_q <= '0;
    end else begin
      pout_q <= pout_d;
    end
  end

  // ==========================================
  // threshold compare
  // threshold concatenation
  assign ths_full = {ths_h_q, pressure_threshold_low_byte_q};
  assign thr = 25'(ths_full) * 25'(THS_SCALE);
  // hidden reference used for compare only
  assign diff = arp_q ? $signed({1'b0, pout_q}) - $signed({1'b0, hid_q})
                      : $signed({1'b0, pout_q});
  assign hi_cmp = cfg_q.differential_compute_enable && cfg_q.high_event_enable && (diff > thr);
  assign lo_cmp = cfg_q.differential_compute_enable && cfg_q.low_event_enable && (diff < -thr);

  // ==========================================
  // interrupt source
  always_comb begin
    src_d = src_q;
    if (cfg_q.latch_interrupt_request) begin
      if (src_rd) begin
        src_d = '0;
      end
      src_d[SRC_HIGH] = src_d[SRC_HIGH] | hi_cmp;
      src_d[SRC_LOW]  = src_d[SRC_LOW] | lo_cmp;
    end else begin
      src_d[SRC_HIGH] = hi_cmp;
      src_d[SRC_LOW]  = lo_cmp;
    end
    src_d[SRC_ACTIVE] = src_d[SRC_HIGH] | src_d[SRC_LOW];
    int_d = src_d[SRC_ACTIVE];
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      src_q <= '0;
      int_q <= 1'b0;
    end else begin
      src_q <= src_d;
      int_q <= int_d;
    end
  end

  // ==========================================
  // read data
  always_comb begin
    rd_d = rd_q;
    if (req.rd) begin
      case (req.addr)
        ADDR_CFG: begin
          rd_d = 8'h00;
          rd_d[BIT_AUTOZERO] = cfg_q.autozero;
          rd_d[BIT_DIFF]     = cfg_q.differential_compute_enable;
          rd_d[BIT_LATCH]    = cfg_q.latch_interrupt_request;
          rd_d[BIT_LOW]      = cfg_q.low_event_enable;
          rd_d[BIT_HIGH]     = cfg_q.high_event_enable;
        end
        ADDR_THS_L:  rd_d = pressure_threshold_low_byte_q;
        ADDR_THS_H:  rd_d = ths_h_q;
        ADDR_REF_XL: rd_d = ref_q[7:0];
        ADDR_REF_L:  rd_d = ref_q[15:8];
        ADDR_REF_H:  rd_d = ref_q[23:16];
        ADDR_DEF_L:  rd_d = def_q[7:0];
        ADDR_DEF_H:  rd_d = def_q[15:8];
        ADDR_SRC:    rd_d = {5'h00, src_q};
        ADDR_OUT_XL: rd_d = pout_q[7:0];
        ADDR_OUT_L:  rd_d = pout_q[15:8];
        ADDR_OUT_H:  rd_d = pout_q[23:16];
        default:     rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rdata        = rd_q;
  assign pressure_out = pout_q;
  assign int_req      = int_q;

  // ==========================================
  // checks
  sequence s_cfg_bit(int b);
    cfg_wr && req.wdata[b];
  endsequence

  sequence s_quiet;
    !cfg_q.differential_compute_enable && !cfg_q.latch_interrupt_request;
  endsequence

  a_diff_gate: assert property (@(posedge mclk) disable iff (!rst_b)
    s_quiet |=> !int_req)
    else $error("interrupt while differential compute disabled");

  a_high_event: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_q.differential_compute_enable && cfg_q.high_event_enable && (diff > thr)
      |=> src_q[SRC_HIGH] && int_req)
    else $error("high event not flagged");

  a_low_event: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_q.differential_compute_enable && cfg_q.low_event_enable && (diff < -thr)
      |=> src_q[SRC_LOW] && int_req)
    else $error("low event not flagged");

  a_auto_ref_load: assert property (@(posedge mclk) disable iff (!rst_b)
    s_cfg_bit(BIT_AUTO_REF) and !req.wdata[BIT_AUTO_REF_RST]
      |=> arp_q && hid_q == $past(pout_q))
    else $error("hidden reference not captured");

  a_out_uncorr: assert property (@(posedge mclk) disable iff (!rst_b)
    sample_valid && !az_q |=> pressure_out == $past(sample_raw))
    else $error("output corrected without autozero");

  a_arp_reset: assert property (@(posedge mclk) disable iff (!rst_b)
    s_cfg_bit(BIT_AUTO_REF_RST) |=> !arp_q ##1
      (arp_q == $past(cfg_wr && req.wdata[BIT_AUTO_REF] && !req.wdata[BIT_AUTO_REF_RST])))
    else $error("hidden reference not disabled");

  a_az_copy: assert property (@(posedge mclk) disable iff (!rst_b)
    s_cfg_bit(BIT_AUTOZERO) and !req.wdata[BIT_AZ_RST] |=> az_q && ref_q == $past(pout_q))
    else $error("autozero copy missing");

  a_az_sub: assert property (@(posedge mclk) disable iff (!rst_b)
    sample_valid && az_q |=> pressure_out == $past(sample_raw - ref_q))
    else $error("autozero subtraction wrong");

  a_az_reset: assert property (@(posedge mclk) disable iff (!rst_b)
    s_cfg_bit(BIT_AZ_RST) |=> !az_q && ref_q == {$past(def_q), 8'h00})
    else $error("autozero reset did not reload default");

  a_latch_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_q.latch_interrupt_request && src_q[SRC_ACTIVE] && !src_rd && !cfg_wr
      |=> src_q[SRC_ACTIVE][*1])
    else $error("latched source dropped before read");

  a_src_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    src_rd && !hi_cmp && !lo_cmp |=> !src_q[SRC_ACTIVE] && !int_req)
    else $error("source not cleared by read");

endmodule : pressure_threshold_interrupt_ref

// >>> design/pth_pkg.sv
package pth_pkg;

  // ==========================================
  // register map
  localparam logic [7:0] ADDR_CFG    = 8'h0b;
  localparam logic [7:0] ADDR_THS_L  = 8'h0c;
  localparam logic [7:0] ADDR_THS_H  = 8'h0d;
  localparam logic [7:0] ADDR_REF_XL = 8'h15;
  localparam logic [7:0] ADDR_REF_L  = 8'h16;
  localparam logic [7:0] ADDR_REF_H  = 8'h17;
  localparam logic [7:0] ADDR_DEF_L  = 8'h18;
  localparam logic [7:0] ADDR_DEF_H  = 8'h19;
  localparam logic [7:0] ADDR_SRC    = 8'h25;
  localparam logic [7:0] ADDR_OUT_XL = 8'h28;
  localparam logic [7:0] ADDR_OUT_L  = 8'h29;
  localparam logic [7:0] ADDR_OUT_H  = 8'h2a;

  // ==========================================
  // configuration bit positions
  localparam int BIT_AUTO_REF     = 7;
  localparam int BIT_AUTO_REF_RST = 6;
  localparam int BIT_AUTOZERO     = 5;
  localparam int BIT_AZ_RST       = 4;
  localparam int BIT_DIFF         = 3;
  localparam int BIT_LATCH        = 2;
  localparam int BIT_LOW          = 1;
  localparam int BIT_HIGH         = 0;

  // source bit positions
  localparam int SRC_HIGH   = 0;
  localparam int SRC_LOW    = 1;
  localparam int SRC_ACTIVE = 2;

  // ==========================================
  // reset values and scaling
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [15:0] RST_REF_DEF    = 16'h0000;
  localparam int          PRESS_PER_HPA  = 4096;
  localparam int          THS_DIV        = 16;
  localparam int          THS_SCALE      = PRESS_PER_HPA / THS_DIV;

  // ==========================================
  // carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic autozero;
    logic differential_compute_enable;
    logic latch_interrupt_request;
    logic low_event_enable;
    logic high_event_enable;
  } cfg_type;

endpackage : pth_pkg

// >>> verif/host_model.sv
`timescale 1ns/1ps

// ==========================================
// host side: register strobes and raw samples
module host_model
  import pth_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic [7:0]     rdata,
  output pth_pkg::reg_req_type req,
  output logic                sample_valid,
  output logic [23:0]         sample_raw
);

  initial begin
    req          = '0;
    sample_valid = 1'b0;
    sample_raw   = 24'h000000;
  end

  // idle address and data show the inverse, not the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    d   = rdata;
  endtask : rd

  task automatic smp(input logic [23:0] r);
    @(negedge mclk);
    sample_valid = 1'b1;
    sample_raw   = r;
    @(negedge mclk);
    sample_valid = 1'b0;
    sample_raw   = ~r;
  endtask : smp

endmodule : host_model

// >>> verif/pressure_threshold_interrupt_ref_bench.sv
`timescale 1ns/1ps

module pressure_threshold_interrupt_ref_bench;
  import pth_pkg::*;

  logic        mclk;
  logic        rst_b;
  reg_req_type req;
  logic [7:0]  rdata;
  logic        sample_valid;
  logic [23:0] sample_raw;
  logic [23:0] pressure_out;
  logic        int_req;
  logic [7:0]  v;
  int          miscompares = 0;
  int          checked     = 0;

  host_model host_u (
    .mclk         (mclk),
    .rdata        (rdata),
    .req          (req),
    .sample_valid (sample_valid),
    .sample_raw   (sample_raw)
  );

  pressure_threshold_interrupt_ref dut_u (
    .mclk         (mclk),
    .rst_b        (rst_b),
    .req          (req),
    .rdata        (rdata),
    .sample_valid (sample_valid),
    .sample_raw   (sample_raw),
    .pressure_out (pressure_out),
    .int_req      (int_req)
  );

  // ==========================================
  // clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    conclude();
  end

  // ==========================================
  // checking helpers
  task automatic conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    check("rdata", {16'h0000, d}, {16'h0000, e});
  endtask : rdchk

  // int_req settles one cycle after the sample edge
  task automatic sc(input logic [23:0] r, input logic [23:0] eo, input logic ei);
    host_u.smp(r);
    check("pressure_out", pressure_out, eo);
    repeat (2) @(negedge mclk);
    check("int_req", {23'h0, int_req}, {23'h0, ei});
  endtask : sc

  // ==========================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    check("int_req", {23'h0, int_req}, 24'h000000);
    check("pressure_out", pressure_out, 24'h000000);
    rdchk(8'h0c, 8'h00);
    rdchk(8'h30, 8'h00);
    host_u.wr(8'h0c, 8'h01);
    rdchk(8'h0c, 8'h01);
    host_u.wr(8'h0b, 8'h09);
    sc(24'd257, 24'd257, 1'b1);
    sc(24'd256, 24'd256, 1'b0);
    host_u.wr(8'h0b, 8'h01);
    sc(24'd1000, 24'd1000, 1'b0);
    host_u.wr(8'h0d, 8'h01);
    host_u.wr(8'h0c, 8'h00);
    host_u.wr(8'h0b, 8'h09);
    sc(24'h010001, 24'h010001, 1'b1);
    sc(24'h010000, 24'h010000, 1'b0);
    host_u.wr(8'h0c, 8'h01);
    host_u.wr(8'h0d, 8'h00);
    sc(24'd1000, 24'd1000, 1'b1);
    host_u.wr(8'h0b, 8'h8a);
    rdchk(8'h0b, 8'h0a);
    sc(24'd743, 24'd743, 1'b1);
    sc(24'd744, 24'd744, 1'b0);
    host_u.wr(8'h0b, 8'h4a);
    rdchk(8'h0b, 8'h0a);
    sc(24'd743, 24'd743, 1'b0);
    host_u.wr(8'h0b, 8'h0d);
    sc(24'd300, 24'd300, 1'b1);
    sc(24'd100, 24'd100, 1'b1);
    rdchk(8'h25, 8'h05);
    repeat (2) @(negedge mclk);
    check("int_req", {23'h0, int_req}, 24'h000000);
    host_u.wr(8'h0b, 8'h00);
    sc(24'h001234, 24'h001234, 1'b0);
    host_u.wr(8'h0b, 8'h20);
    rdchk(8'h15, 8'h34);
    rdchk(8'h16, 8'h12);
    rdchk(8'h17, 8'h00);
    sc(24'h002000, 24'h000dcc, 1'b0);
    host_u.wr(8'h15, 8'h00);
    host_u.wr(8'h16, 8'h00);
    host_u.wr(8'h17, 8'h00);
    sc(24'h002000, 24'h002000, 1'b0);
    host_u.wr(8'h18, 8'h05);
    host_u.wr(8'h0b, 8'h30);
    rdchk(8'h16, 8'h05);
    rdchk(8'h15, 8'h00);
    host_u.rd(8'h0b, v);
    check("cfg_az_reset", {16'h0000, v}, 24'h000000);
    sc(24'h002000, 24'h002000, 1'b0);
    conclude();
  end

endmodule : pressure_threshold_interrupt_ref_bench
